// *** logic/cgm_regs.svh ***
// Register offsets, field positions and reset values of the clock generator
`ifndef CGM_REGS_SVH
`define CGM_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CGM_OFF_CTRL 8'h00
`define CGM_OFF_BW 8'h04
`define CGM_OFF_MULT 8'h08
`define CGM_OFF_RANGE 8'h0C
`define CGM_OFF_REFDIV 8'h10
`define CGM_OFF_CONFIG 8'h14

// ****************************************************************
// Field positions
// ****************************************************************
`define CGM_CTRL_IRQ_EN 7
`define CGM_CTRL_FLAG 6
`define CGM_CTRL_LOOP_ON 5
`define CGM_CTRL_BCS 4
`define CGM_CTRL_PRESC_LO 0
`define CGM_BW_AUTO 7
`define CGM_BW_LOCK 6
`define CGM_BW_TRACK 5
`define CGM_RANGE_E_LO 8
`define CGM_CFG_OSC_STOP 0

// ****************************************************************
// Reset values and fixed counts
// ****************************************************************
`define CGM_RST_MULT 12'h0_001
`define CGM_RST_RANGE 8'h0_0
`define CGM_RST_E 2'h0
`define CGM_RST_REFDIV 4'h1
`define CGM_RST_PRESC 2'h0
`define CGM_DIV_HALF 12'h0_002
`define CGM_GOOD_PERIODS 2'h2

`endif

// *** logic/cgm_pkg.sv ***
// Types shared by the clock generator design
package cgm_pkg;
    // Loop filter operating state
    typedef enum logic [1:0] {ST_ACQUIRE, ST_TRACK, ST_LOCKED} filter_state_type;

    // Software control fields of the control register
    typedef struct packed {
        logic irq_en;
        logic loop_on;
        logic base_clock_select;
        logic [1:0] presc;
    } ctrl_type;

    // Loop programming fields
    typedef struct packed {
        logic [11:0] mult;
        logic [7:0] range;
        logic [1:0] e;
        logic [3:0] refdiv;
    } prog_type;
endpackage : cgm_pkg

// *** logic/clk_divider.sv ***
// Modulo divider counting input ticks, with level and tick outputs
`timescale 1ns/100ps
`default_nettype none
module clk_divider (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Input ticks and modulus
    input wire logic in_tick,
    input wire logic [11:0] div,
    // Divided outputs
    output logic out_tick,
    output logic out_level
);
    logic [11:0] count_q;
    logic [11:0] last;
    logic [11:0] count_d;

    // Zero modulus treated as one so the output never stalls
    always_comb begin
        last = (div == 12'h0_000) ? 12'h0_000 : div - 12'h0_001;
        count_d = (count_q >= last) ? 12'h0_000 : count_q + 12'h0_001;
    end

    // Count ticks; level high for the first half of each period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_q <= 12'h0_000;
            out_tick <= 1'b0;
            out_level <= 1'b0;
        end else begin
            out_tick <= in_tick && (count_q >= last);
            if (in_tick) begin
                count_q <= count_d;
            end
            // Divide by one passes each tick as a one-cycle pulse: a level stuck high
            // would lose the clock, so rate is kept at the cost of duty cycle
            if (last == 12'h0_000) begin
                out_level <= in_tick;
            end else if (in_tick) begin
                out_level <= count_d < ((last + 12'h0_001) >> 1);
            end
        end
    end
endmodule : clk_divider
`default_nettype wire

// *** logic/pll_base_clock_generator.sv ***
// Digital control side of the PLL base clock generator with AHB-Lite registers
`timescale 1ns/100ps
`default_nettype none
`include "cgm_regs.svh"
module pll_base_clock_generator
    import cgm_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // System integration and clock sources
    input wire logic osc_enable_from_sysint,
    input wire logic stop_mode,
    input wire logic osc_clock,
    input wire logic vco_clock,
    // Clock and loop outputs
    output logic osc_run,
    output logic pll_ref_clock,
    output logic final_ref_clock,
    output logic vco_feedback_clock,
    output logic base_clock_out,
    output logic bus_clock_out,
    output logic pump_up,
    output logic pump_down,
    output logic filter_tracking,
    output logic lock_irq
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    ctrl_type ctrl_q;
    prog_type prog_q;
    logic auto_q, manual_track_q, osc_stop_en_q, flag_q, lock_q;
    logic wr_pend_q, rd_take;
    logic [7:0] wr_addr_q;
    logic osc_prev_q, vco_prev_q, osc_tick, vco_tick;
    logic sel_vco_q, src_tick, base_tick, base_level, bus_level;
    logic ref_tick, presc_tick, fb_tick, ref_level, fb_level;
    logic [11:0] presc_div;
    logic [1:0] fb_cnt_q, good_q;
    logic period_good;
    logic up_q, dn_q;
    filter_state_type state_q;
    logic [31:0] rd_word;

    // ****************************************************************
    // AHB-Lite slave: zero wait state, always OKAY
    // ****************************************************************
    assign rd_take = hsel && htrans[1] && hready && !hwrite;

    // Address phase capture for a write; data follows next cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h0_0;
        end else begin
            wr_pend_q <= hsel && htrans[1] && hready && hwrite;
            wr_addr_q <= haddr[7:0];
        end
    end

    // Response signals stay constant: every access completes at once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        case (haddr[7:0])
            `CGM_OFF_CTRL: begin
                rd_word[`CGM_CTRL_IRQ_EN] = ctrl_q.irq_en;
                rd_word[`CGM_CTRL_FLAG] = flag_q && auto_q;
                rd_word[`CGM_CTRL_LOOP_ON] = ctrl_q.loop_on;
                rd_word[`CGM_CTRL_BCS] = ctrl_q.base_clock_select;
                rd_word[`CGM_CTRL_PRESC_LO +: 2] = ctrl_q.presc;
            end
            `CGM_OFF_BW: begin
                rd_word[`CGM_BW_AUTO] = auto_q;
                rd_word[`CGM_BW_LOCK] = lock_q && auto_q;
                rd_word[`CGM_BW_TRACK] = filter_tracking;
            end
            `CGM_OFF_MULT: rd_word[11:0] = prog_q.mult;
            `CGM_OFF_RANGE: begin
                rd_word[7:0] = prog_q.range;
                rd_word[`CGM_RANGE_E_LO +: 2] = prog_q.e;
            end
            `CGM_OFF_REFDIV: rd_word[3:0] = prog_q.refdiv;
            `CGM_OFF_CONFIG: rd_word[`CGM_CFG_OSC_STOP] = osc_stop_en_q;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // Read data registered at the address phase, valid in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_take) begin
            hrdata <= rd_word;
        end
    end

    // ****************************************************************
    // Control register with interlocks
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= '{irq_en: 1'b0, loop_on: 1'b0, base_clock_select: 1'b0, presc: `CGM_RST_PRESC};
        end else begin
            if (wr_pend_q && wr_addr_q == `CGM_OFF_CTRL) begin
                ctrl_q.irq_en <= hwdata[`CGM_CTRL_IRQ_EN] && auto_q;
                ctrl_q.loop_on <= hwdata[`CGM_CTRL_LOOP_ON] || ctrl_q.base_clock_select;
                ctrl_q.base_clock_select <= hwdata[`CGM_CTRL_BCS] && ctrl_q.loop_on
                    && hwdata[`CGM_CTRL_LOOP_ON] && (prog_q.range != 8'h0_0);
                if (!ctrl_q.loop_on) begin
                    ctrl_q.presc <= hwdata[`CGM_CTRL_PRESC_LO +: 2];
                end
            end else begin
                if (!auto_q) begin
                    ctrl_q.irq_en <= 1'b0;
                end
                if (!ctrl_q.loop_on || prog_q.range == 8'h0_0) begin
                    ctrl_q.base_clock_select <= 1'b0;
                end
            end
        end
    end

    // Loop programming: frozen while the loop runs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prog_q <= '{mult: `CGM_RST_MULT, range: `CGM_RST_RANGE, e: `CGM_RST_E,
                        refdiv: `CGM_RST_REFDIV};
        end else if (wr_pend_q && !ctrl_q.loop_on) begin
            case (wr_addr_q)
                `CGM_OFF_MULT: prog_q.mult <= hwdata[11:0];
                `CGM_OFF_RANGE: begin
                    prog_q.range <= hwdata[7:0];
                    prog_q.e <= hwdata[`CGM_RANGE_E_LO +: 2];
                end
                `CGM_OFF_REFDIV: prog_q.refdiv <= hwdata[3:0];
                default: prog_q <= prog_q;
            endcase
        end
    end

    // Bandwidth and configuration bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            auto_q <= 1'b0;
            manual_track_q <= 1'b0;
            osc_stop_en_q <= 1'b0;
        end else if (wr_pend_q) begin
            if (wr_addr_q == `CGM_OFF_BW) begin
                auto_q <= hwdata[`CGM_BW_AUTO];
                manual_track_q <= hwdata[`CGM_BW_TRACK];
            end
            if (wr_addr_q == `CGM_OFF_CONFIG) begin
                osc_stop_en_q <= hwdata[`CGM_CFG_OSC_STOP];
            end
        end
    end

    // ****************************************************************
    // Oscillator gating and source edge detection
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_run <= 1'b0;
            pll_ref_clock <= 1'b0;
            osc_prev_q <= 1'b0;
            vco_prev_q <= 1'b0;
        end else begin
            osc_run <= osc_enable_from_sysint && (!stop_mode || osc_stop_en_q);
            pll_ref_clock <= osc_clock && osc_run;
            osc_prev_q <= pll_ref_clock;
            vco_prev_q <= vco_clock;
        end
    end

    assign osc_tick = pll_ref_clock && !osc_prev_q;
    assign vco_tick = vco_clock && !vco_prev_q && ctrl_q.loop_on;

    // ****************************************************************
    // Reference and feedback dividers
    // ****************************************************************
    assign presc_div = 12'h0_001 << ctrl_q.presc;

    clk_divider u_ref_div (.hclk(hclk), .hresetn(hresetn), .in_tick(osc_tick),
        .div({8'h0_0, prog_q.refdiv}), .out_tick(ref_tick), .out_level(ref_level));
    clk_divider u_presc (.hclk(hclk), .hresetn(hresetn), .in_tick(vco_tick),
        .div(presc_div), .out_tick(presc_tick), .out_level());
    clk_divider u_fb_div (.hclk(hclk), .hresetn(hresetn), .in_tick(presc_tick),
        .div(prog_q.mult), .out_tick(fb_tick), .out_level(fb_level));

    // Divided clocks re-registered so the outputs come straight from flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            final_ref_clock <= 1'b0;
            vco_feedback_clock <= 1'b0;
        end else begin
            final_ref_clock <= ref_level;
            vco_feedback_clock <= fb_level;
        end
    end

    // ****************************************************************
    // Phase detector: up on reference lead, down on feedback lead
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
        end else if (!ctrl_q.loop_on || (up_q || ref_tick) && (dn_q || fb_tick)) begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
        end else begin
            up_q <= up_q || ref_tick;
            dn_q <= dn_q || fb_tick;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pump_up <= 1'b0;
            pump_down <= 1'b0;
        end else begin
            pump_up <= up_q;
            pump_down <= dn_q;
        end
    end

    // ****************************************************************
    // Lock detector: one feedback edge per reference period is in tolerance
    // ****************************************************************
    assign period_good = (fb_cnt_q + {1'b0, fb_tick}) == 2'h1;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fb_cnt_q <= 2'h0;
        end else if (ref_tick) begin
            fb_cnt_q <= 2'h0;
        end else if (fb_tick && fb_cnt_q != 2'h3) begin
            fb_cnt_q <= fb_cnt_q + 2'h1; // Saturates: any excess is out of tolerance
        end
    end

    // Filter state: a bad period drops back to acquisition
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_ACQUIRE;
            good_q <= 2'h0;
        end else if (!ctrl_q.loop_on || !auto_q) begin
            state_q <= ST_ACQUIRE;
            good_q <= 2'h0;
        end else if (ref_tick) begin
            case (state_q)
                ST_ACQUIRE: begin
                    good_q <= period_good ? good_q + 2'h1 : 2'h0;
                    if (period_good && good_q + 2'h1 == `CGM_GOOD_PERIODS) begin
                        state_q <= ST_TRACK;
                        good_q <= 2'h0;
                    end
                end
                ST_TRACK: state_q <= period_good ? ST_LOCKED : ST_ACQUIRE;
                ST_LOCKED: state_q <= period_good ? ST_LOCKED : ST_ACQUIRE;
                default: state_q <= ST_ACQUIRE;
            endcase
        end
    end

    // Lock, lock-change flag and interrupt; a new change beats the read clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_q <= 1'b0;
            flag_q <= 1'b0;
            lock_irq <= 1'b0;
            filter_tracking <= 1'b0;
        end else begin
            lock_q <= (state_q == ST_LOCKED);
            if (auto_q && (lock_q != (state_q == ST_LOCKED))) begin
                flag_q <= 1'b1;
            end else if (!auto_q || rd_take && haddr[7:0] == `CGM_OFF_CTRL) begin
                flag_q <= 1'b0;
            end
            lock_irq <= flag_q && ctrl_q.irq_en && auto_q;
            filter_tracking <= auto_q ? (state_q != ST_ACQUIRE) : manual_track_q;
        end
    end

    // ****************************************************************
    // Base clock selector and bus clock
    // ****************************************************************
    // Switch only while the base clock is low, at an edge of the new source
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_vco_q <= 1'b0;
        end else if (!base_level && (ctrl_q.base_clock_select ? vco_tick : osc_tick)) begin
            sel_vco_q <= ctrl_q.base_clock_select;
        end
    end

    assign src_tick = sel_vco_q ? vco_tick : osc_tick;

    clk_divider u_base_div (.hclk(hclk), .hresetn(hresetn), .in_tick(src_tick),
        .div(`CGM_DIV_HALF), .out_tick(base_tick), .out_level(base_level));
    clk_divider u_bus_div (.hclk(hclk), .hresetn(hresetn), .in_tick(base_tick),
        .div(`CGM_DIV_HALF), .out_tick(), .out_level(bus_level));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            base_clock_out <= 1'b0;
            bus_clock_out <= 1'b0;
        end else begin
            base_clock_out <= base_level;
            bus_clock_out <= bus_level;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_manual;
        !auto_q;
    endsequence
    sequence s_flag_dropped;
        ##1 !flag_q && !lock_q;
    endsequence

    property p_irq_en_manual;
        @(posedge hclk) disable iff (!hresetn) s_manual ##1 !auto_q |-> !ctrl_q.irq_en;
    endproperty
    a_irq_en_manual: assert property (p_irq_en_manual) else $error("irq enable set in manual");

    property p_manual_zero;
        @(posedge hclk) disable iff (!hresetn) s_manual ##1 !auto_q |-> s_flag_dropped;
    endproperty
    a_manual_zero: assert property (p_manual_zero) else $error("flag or lock in manual");

    property p_bcs_forced;
        @(posedge hclk) disable iff (!hresetn)
            (!ctrl_q.loop_on || prog_q.range == 8'h0_0) |=> !ctrl_q.base_clock_select;
    endproperty
    a_bcs_forced: assert property (p_bcs_forced) else $error("bcs set without loop");

    property p_prog_frozen;
        @(posedge hclk) disable iff (!hresetn) ctrl_q.loop_on |=> $stable(prog_q);
    endproperty
    a_prog_frozen: assert property (p_prog_frozen) else $error("programming changed");

    property p_loop_kept;
        @(posedge hclk) disable iff (!hresetn) ctrl_q.base_clock_select |=> ctrl_q.loop_on;
    endproperty
    a_loop_kept: assert property (p_loop_kept) else $error("loop off with bcs set");

    property p_osc_gate;
        @(posedge hclk) disable iff (!hresetn) !osc_run |=> !pll_ref_clock;
    endproperty
    a_osc_gate: assert property (p_osc_gate) else $error("reference runs while off");

    property p_pump_exclusive;
        @(posedge hclk) disable iff (!hresetn) !(pump_up && pump_down);
    endproperty
    a_pump_exclusive: assert property (p_pump_exclusive) else $error("both pumps on");

    property p_base_follows_src;
        @(posedge hclk) disable iff (!hresetn) $changed(base_level) |-> $past(src_tick);
    endproperty
    a_base_follows_src: assert property (p_base_follows_src) else $error("base moved");

    property p_bus_follows_base;
        @(posedge hclk) disable iff (!hresetn) $changed(bus_level) |-> $past(base_tick);
    endproperty
    a_bus_follows_base: assert property (p_bus_follows_base) else $error("bus moved");
endmodule : pll_base_clock_generator
`default_nettype wire

// *** testbench/osc_vco_model.sv ***
// Behavioural crystal oscillator and VCO driving the clock generator
`timescale 1ns/100ps
`default_nettype none
module osc_vco_model #(
    parameter int HALF = 4
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Oscillator run request
    input wire logic osc_run,
    // Source clocks
    output logic osc_clock,
    output logic vco_clock
);
    int cnt_q;
    // VCO toggles every HALF cycles, the crystal too while osc_run; slow enough to be sampled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 0;
            osc_clock <= 1'b0;
            vco_clock <= 1'b0;
        end else begin
            cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
            if (cnt_q == HALF - 1) begin
                vco_clock <= ~vco_clock;
                // Crystal stands still unless running
                if (osc_run) begin
                    osc_clock <= ~osc_clock;
                end
            end
        end
    end
endmodule : osc_vco_model
`default_nettype wire

// *** testbench/tb.sv ***
// Register-level test of the PLL base clock generator
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, osc_en = 1, stop = 0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
    logic [1:0] htrans = 2'h0;
    logic hreadyout, hresp, osc_run, osc_clk, vco_clk, base_clk, bus_clk, irq, use_vco = 0;
    logic ref_clk_raw, ref_div_clk, fb_div_clk, pump_up, pump_down;
    int err_total = 0, comparisons = 0, n_src, n_base, n_bus, i, n_ref, n_fb, n_pump;
    logic [31:0] bw;
    // ****************************************************************
    // Clock, design and partner
    // ****************************************************************
    always #20 hclk = ~hclk;
    pll_base_clock_generator dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .osc_enable_from_sysint(osc_en), .stop_mode(stop), .osc_clock(osc_clk),
        .vco_clock(vco_clk), .osc_run(osc_run), .pll_ref_clock(ref_clk_raw),
        .final_ref_clock(ref_div_clk), .vco_feedback_clock(fb_div_clk),
        .base_clock_out(base_clk), .bus_clock_out(bus_clk), .pump_up(pump_up),
        .pump_down(pump_down), .filter_tracking(), .lock_irq(irq));
    osc_vco_model part (.hclk(hclk), .hresetn(hresetn), .osc_run(osc_run),
        .osc_clock(osc_clk), .vco_clock(vco_clk));
    // Rising edges of the clocks under watch
    always @(posedge base_clk) n_base++;
    always @(posedge bus_clk) n_bus++;
    always @(posedge osc_clk) if (!use_vco) n_src++;
    always @(posedge vco_clk) if (use_vco) n_src++;
    always @(posedge ref_div_clk) n_ref++;
    always @(posedge fb_div_clk) n_fb++;
    // Correction pulse cycles; aligned equal-rate sources should give none
    always @(posedge hclk) if (pump_up === 1'b1 || pump_down === 1'b1) n_pump++;
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task end_sim;
        $display("comparisons %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Bounded wait for hready at a rising edge
    task wait_rdy;
        int k;
        for (k = 0; k < 20; k++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) break;
        end
        if (k == 20) begin
            err_total++;
            $display("Error %0t: bus hang", $time);
            end_sim;
        end
    endtask : wait_rdy
    task xfer(input logic w, input logic [7:0] a, input logic [11:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {20'h0_0000, d};
        wait_rdy;
    endtask : xfer
    task wr(input logic [7:0] a, input logic [11:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task rd(input logic [7:0] a, input logic [11:0] e);
        xfer(1'b0, a, 12'h000);
        chk(hrdata, {20'h0_0000, e});
    endtask : rd
    // Base must run at half the source, bus at half the base
    task rate;
        n_src = 0;
        n_base = 0;
        n_bus = 0;
        n_ref = 0;
        n_fb = 0;
        n_pump = 0;
        repeat (160) @(posedge hclk);
        chk({31'h0, (n_src - 2 * n_base) inside {[-2:2]}}, 32'h0000_0001);
        chk({31'h0, (n_base - 2 * n_bus) inside {[-2:2]}}, 32'h0000_0001);
        chk({31'h0, (n_src - n_ref) inside {[-2:2]}}, 32'h0000_0001);
    endtask : rate
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rd(8'h00, 12'h000);
        rd(8'h08, 12'h001);
        rd(8'h10, 12'h001);
        rd(8'h18, 12'h000);
        wr(8'h10, 12'h001);
        wr(8'h0C, 12'h110);
        rd(8'h0C, 12'h110);
        wr(8'h00, 12'h080);
        rd(8'h00, 12'h000);
        wr(8'h00, 12'h010);
        rd(8'h00, 12'h000);
        rate;
        wr(8'h00, 12'h020);
        wr(8'h08, 12'h005);
        rd(8'h08, 12'h001);
        wr(8'h0C, 12'h000);
        rd(8'h0C, 12'h110);
        wr(8'h04, 12'h080);
        wr(8'h00, 12'h0A0);
        // Poll the lock bit with a bounded count
        for (i = 0; i < 100; i++) begin
            xfer(1'b0, 8'h04, 12'h000);
            bw = hrdata;
            if (bw[6] === 1'b1) break;
        end
        chk(bw, 32'h0000_00E0);
        chk({31'h0, irq}, 32'h0000_0001);
        rd(8'h00, 12'h0E0);
        @(posedge hclk);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(8'h00, 12'h0B0);
        rd(8'h00, 12'h0B0);
        wr(8'h00, 12'h080);
        rd(8'h00, 12'h0A0);
        wr(8'h00, 12'h0B0);
        use_vco = 1'b1;
        rate;
        chk({31'h0, (n_src - n_fb) inside {[-2:2]}}, 32'h0000_0001);
        chk(n_pump, 32'h0000_0000);
        wr(8'h04, 12'h000);
        rd(8'h04, 12'h000);
        rd(8'h00, 12'h030);
        osc_en <= 1'b0;
        repeat (3) @(posedge hclk);
        chk({31'h0, osc_run}, 32'h0000_0000);
        chk({31'h0, ref_clk_raw}, 32'h0000_0000);
        osc_en <= 1'b1;
        stop <= 1'b1;
        repeat (3) @(posedge hclk);
        chk({31'h0, osc_run}, 32'h0000_0000);
        wr(8'h14, 12'h001);
        repeat (3) @(posedge hclk);
        chk({31'h0, osc_run}, 32'h0000_0001);
        end_sim;
    end
endmodule : tb
`default_nettype wire
